/* common/host_link_defs.svh */
// Notes on behaviour
// - Characters: start, eight data LSB first, stop.
// - RTS/CTS handshake gates both directions.
// - Commands inbound, responses outbound, always packets.
// - Packets 1-16 bytes; longer in some modes.
// - Header byte never reaches the network.
// - Header: type upper nibble, count lower nibble.
// - Type nibble meaning differs by direction.
// - Over 15 following bytes needs alternate header.
// - Append checksum to transmitted message, switchable.
// - LIN role chosen per message by host.
// - Unassigned LIN role: forward all traffic.
// - Alternate form one: 11, one count byte.
// - Alternate form two: 12, count MSB first.
// - Receive response: type zero, status, message.
`ifndef HOST_LINK_DEFS_SVH
`define HOST_LINK_DEFS_SVH

`define HDR_ALT1        8'h11
`define HDR_ALT2        8'h12
`define TYPE_NET_MSG    4'h0
`define MAX_NORMAL_CNT  8'h0F
`define CLK_HZ          250000000
`define BAUD_RATE       115200
`define BIT_CYCLES      (`CLK_HZ / `BAUD_RATE)
`define RESP_DEPTH      32

`endif

/* common/host_link_pkg.sv */
`include "host_link_defs.svh"

package host_link_pkg;

	typedef enum logic [1:0] {
		CH_IDLE  = 2'h0,
		CH_START = 2'h1,
		CH_DATA  = 2'h2,
		CH_STOP  = 2'h3
	} char_state_t;

	typedef enum logic [2:0] {
		IN_HDR  = 3'h0,
		IN_LEN1 = 3'h1,
		IN_LENH = 3'h2,
		IN_LENL = 3'h3,
		IN_BODY = 3'h4,
		IN_SUM  = 3'h5
	} in_state_t;

	typedef enum logic [2:0] {
		RS_COLLECT = 3'h0,
		RS_HDR     = 3'h1,
		RS_CNT     = 3'h2,
		RS_STAT    = 3'h3,
		RS_DATA    = 3'h4
	} resp_state_t;

	typedef enum logic [1:0] {
		ROLE_PASSIVE = 2'h0,
		ROLE_MASTER  = 2'h1,
		ROLE_SLAVE   = 2'h2
	} lin_role_t;

	typedef struct packed {
		logic        rx_meta;
		logic        rx_sync;
		char_state_t rx_st;
		logic [11:0] rx_cnt;
		logic [2:0]  rx_bit;
		logic [7:0]  rx_sh;
		logic [7:0]  rx_data;
		logic        rx_valid;
		char_state_t tx_st;
		logic [11:0] tx_cnt;
		logic [2:0]  tx_bit;
		logic [7:0]  tx_sh;
		logic        txd;
	} char_regs_t;

	typedef struct packed {
		logic                          cts_meta;
		logic                          cts_sync;
		in_state_t                     in_st;
		logic                          pend;
		logic [7:0]                    pend_data;
		logic                          is_net;
		logic                          first;
		logic                          sum_en;
		logic [15:0]                   remain;
		logic [7:0]                    sum;
		logic                          rts;
		logic [7:0]                    ntx_data;
		logic                          ntx_valid;
		logic                          ntx_first;
		logic                          ntx_last;
		lin_role_t                     ntx_role;
		logic [7:0]                    cmd_data;
		logic                          cmd_valid;
		logic                          cmd_first;
		logic                          cmd_last;
		resp_state_t                   rs_st;
		logic [`RESP_DEPTH-1:0][7:0]   rbuf;
		logic [5:0]                    rlen;
		logic [4:0]                    ridx;
		logic [7:0]                    rstat;
		logic                          nrx_ready;
	} link_regs_t;

endpackage

/* design/serial_char_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "host_link_defs.svh"

module serial_char_engine (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       rxd_pin,
	output logic            txd_pin,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);

	localparam logic [11:0] BIT_CNT  = 12'(`BIT_CYCLES - 1);
	localparam logic [11:0] HALF_CNT = 12'(`BIT_CYCLES / 2);

	host_link_pkg::char_regs_t s_r;
	host_link_pkg::char_regs_t s_nxt;

	assign txd_pin  = s_r.txd;
	assign rx_data  = s_r.rx_data;
	assign rx_valid = s_r.rx_valid;
	assign tx_ready = (s_r.tx_st == host_link_pkg::CH_IDLE);

	always_comb begin
		s_nxt          = s_r;
		s_nxt.rx_meta  = rxd_pin;
		s_nxt.rx_sync  = s_r.rx_meta;
		s_nxt.rx_valid = 1'b0;
		s_nxt.rx_cnt   = s_r.rx_cnt - 12'h001;
		// Receiver: mid-bit sampling, frame dropped on bad stop
		case (s_r.rx_st)
			host_link_pkg::CH_IDLE: begin
				if (!s_r.rx_sync) begin
					s_nxt.rx_st  = host_link_pkg::CH_START;
					s_nxt.rx_cnt = HALF_CNT;
				end
			end
			host_link_pkg::CH_START: begin
				if (s_r.rx_cnt == 12'h000) begin
					s_nxt.rx_cnt = BIT_CNT;
					s_nxt.rx_bit = 3'h0;
					s_nxt.rx_st  = s_r.rx_sync ? host_link_pkg::CH_IDLE : host_link_pkg::CH_DATA;
				end
			end
			host_link_pkg::CH_DATA: begin
				if (s_r.rx_cnt == 12'h000) begin
					s_nxt.rx_sh  = {s_r.rx_sync, s_r.rx_sh[7:1]};
					s_nxt.rx_cnt = BIT_CNT;
					s_nxt.rx_bit = s_r.rx_bit + 3'h1;
					if (s_r.rx_bit == 3'h7) begin
						s_nxt.rx_st = host_link_pkg::CH_STOP;
					end
				end
			end
			host_link_pkg::CH_STOP: begin
				if (s_r.rx_cnt == 12'h000) begin
					s_nxt.rx_st = host_link_pkg::CH_IDLE;
					if (s_r.rx_sync) begin
						s_nxt.rx_data  = s_r.rx_sh;
						s_nxt.rx_valid = 1'b1;
					end
				end
			end
			default: s_nxt.rx_st = host_link_pkg::CH_IDLE;
		endcase
		// Transmitter
		s_nxt.tx_cnt = s_r.tx_cnt - 12'h001;
		case (s_r.tx_st)
			host_link_pkg::CH_IDLE: begin
				s_nxt.txd = 1'b1;
				if (tx_valid) begin
					s_nxt.tx_sh  = tx_data;
					s_nxt.txd    = 1'b0;
					s_nxt.tx_cnt = BIT_CNT;
					s_nxt.tx_st  = host_link_pkg::CH_START;
				end
			end
			host_link_pkg::CH_START: begin
				if (s_r.tx_cnt == 12'h000) begin
					s_nxt.txd    = s_r.tx_sh[0];
					s_nxt.tx_sh  = {1'b0, s_r.tx_sh[7:1]};
					s_nxt.tx_bit = 3'h0;
					s_nxt.tx_cnt = BIT_CNT;
					s_nxt.tx_st  = host_link_pkg::CH_DATA;
				end
			end
			host_link_pkg::CH_DATA: begin
				if (s_r.tx_cnt == 12'h000) begin
					s_nxt.tx_cnt = BIT_CNT;
					s_nxt.tx_bit = s_r.tx_bit + 3'h1;
					if (s_r.tx_bit == 3'h7) begin
						s_nxt.txd   = 1'b1;
						s_nxt.tx_st = host_link_pkg::CH_STOP;
					end else begin
						s_nxt.txd   = s_r.tx_sh[0];
						s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
					end
				end
			end
			host_link_pkg::CH_STOP: begin
				if (s_r.tx_cnt == 12'h000) begin
					s_nxt.tx_st = host_link_pkg::CH_IDLE;
				end
			end
			default: s_nxt.tx_st = host_link_pkg::CH_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r         <= '0;
			s_r.rx_meta <= 1'b1;
			s_r.rx_sync <= 1'b1;
			s_r.txd     <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule // serial_char_engine

`default_nettype wire

/* design/host_serial_packet_link.sv */
`timescale 1ns/1ps
`default_nettype none
`include "host_link_defs.svh"

module host_serial_packet_link (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       host_rxd,
	output logic            host_txd,
	input  wire logic       host_cts,
	output logic            host_rts,
	input  wire logic       sum_append_en,
	input  wire logic       strip_sum_en,
	input  wire logic       lin_mode,
	input  wire logic [1:0] lin_role,
	output logic [7:0]      net_tx_data,
	output logic            net_tx_valid,
	output logic            net_tx_first,
	output logic            net_tx_last,
	output logic [1:0]      net_tx_role,
	input  wire logic       net_tx_ready,
	output logic [7:0]      cmd_data,
	output logic            cmd_valid,
	output logic            cmd_first,
	output logic            cmd_last,
	input  wire logic       cmd_ready,
	input  wire logic [7:0] net_rx_data,
	input  wire logic       net_rx_valid,
	input  wire logic       net_rx_last,
	input  wire logic [7:0] net_rx_status,
	output logic            net_rx_ready
);

	host_link_pkg::link_regs_t s_r;
	host_link_pkg::link_regs_t s_nxt;

	logic [7:0] char_rx_data;
	logic       char_rx_valid;
	logic [7:0] char_tx_data;
	logic       char_tx_valid;
	logic       char_tx_ready;
	logic [7:0] b;
	logic [7:0] resp_total;

	serial_char_engine serial_char_engine_i (
		.clk      (clk),
		.rst      (rst),
		.rxd_pin  (host_rxd),
		.txd_pin  (host_txd),
		.rx_data  (char_rx_data),
		.rx_valid (char_rx_valid),
		.tx_data  (char_tx_data),
		.tx_valid (char_tx_valid),
		.tx_ready (char_tx_ready)
	);

	assign host_rts     = s_r.rts;
	assign net_tx_data  = s_r.ntx_data;
	assign net_tx_valid = s_r.ntx_valid;
	assign net_tx_first = s_r.ntx_first;
	assign net_tx_last  = s_r.ntx_last;
	assign net_tx_role  = s_r.ntx_role;
	assign cmd_data     = s_r.cmd_data;
	assign cmd_valid    = s_r.cmd_valid;
	assign cmd_first    = s_r.cmd_first;
	assign cmd_last     = s_r.cmd_last;
	assign net_rx_ready = s_r.nrx_ready;

	assign b          = s_r.pend_data;
	assign resp_total = {2'h0, s_r.rlen} + 8'h01;

	// Response byte to host, only while host signals ready
	always_comb begin
		char_tx_valid = s_r.cts_sync && (s_r.rs_st != host_link_pkg::RS_COLLECT);
		case (s_r.rs_st)
			host_link_pkg::RS_HDR:  char_tx_data = (resp_total > `MAX_NORMAL_CNT) ? `HDR_ALT1
				: {`TYPE_NET_MSG, resp_total[3:0]};
			host_link_pkg::RS_CNT:  char_tx_data = resp_total;
			host_link_pkg::RS_STAT: char_tx_data = s_r.rstat;
			host_link_pkg::RS_DATA: char_tx_data = s_r.rbuf[s_r.ridx];
			default:                char_tx_data = 8'h00;
		endcase
	end

	always_comb begin
		s_nxt           = s_r;
		s_nxt.cts_meta  = host_cts;
		s_nxt.cts_sync  = s_r.cts_meta;
		s_nxt.ntx_valid = s_r.ntx_valid && !net_tx_ready;
		s_nxt.cmd_valid = s_r.cmd_valid && !cmd_ready;
		// Marks only stand with their byte
		s_nxt.ntx_first = s_r.ntx_first && s_nxt.ntx_valid;
		s_nxt.ntx_last  = s_r.ntx_last && s_nxt.ntx_valid;
		s_nxt.cmd_first = s_r.cmd_first && s_nxt.cmd_valid;
		s_nxt.cmd_last  = s_r.cmd_last && s_nxt.cmd_valid;

		// Inbound command parsing; header type selects network message or command
		case (s_r.in_st)
			host_link_pkg::IN_HDR: begin
				if (s_r.pend) begin
					if (b == `HDR_ALT1) begin
						s_nxt.pend  = 1'b0;
						s_nxt.in_st = host_link_pkg::IN_LEN1;
					end else if (b == `HDR_ALT2) begin
						s_nxt.pend  = 1'b0;
						s_nxt.in_st = host_link_pkg::IN_LENH;
					end else if (b[7:4] == `TYPE_NET_MSG) begin
						s_nxt.pend   = 1'b0;
						s_nxt.remain = {12'h000, b[3:0]};
						s_nxt.in_st  = (b[3:0] != 4'h0) ? host_link_pkg::IN_BODY : host_link_pkg::IN_HDR;
					end else if (!s_r.cmd_valid) begin
						s_nxt.pend      = 1'b0;
						s_nxt.is_net    = 1'b0;
						s_nxt.cmd_data  = b;
						s_nxt.cmd_valid = 1'b1;
						s_nxt.cmd_first = 1'b1;
						s_nxt.cmd_last  = (b[3:0] == 4'h0);
						s_nxt.remain    = {12'h000, b[3:0]};
						s_nxt.in_st     = (b[3:0] != 4'h0) ? host_link_pkg::IN_BODY : host_link_pkg::IN_HDR;
					end
				end
			end
			host_link_pkg::IN_LEN1: begin
				if (s_r.pend) begin
					s_nxt.pend   = 1'b0;
					s_nxt.remain = {8'h00, b};
					s_nxt.in_st  = (b != 8'h00) ? host_link_pkg::IN_BODY : host_link_pkg::IN_HDR;
				end
			end
			host_link_pkg::IN_LENH: begin
				if (s_r.pend) begin
					s_nxt.pend          = 1'b0;
					s_nxt.remain[15:8]  = b;
					s_nxt.in_st         = host_link_pkg::IN_LENL;
				end
			end
			host_link_pkg::IN_LENL: begin
				if (s_r.pend) begin
					s_nxt.pend   = 1'b0;
					s_nxt.remain = {s_r.remain[15:8], b};
					s_nxt.in_st  = ({s_r.remain[15:8], b} != 16'h0000) ? host_link_pkg::IN_BODY
						: host_link_pkg::IN_HDR;
				end
			end
			host_link_pkg::IN_BODY: begin
				if (s_r.pend && s_r.is_net && !s_r.ntx_valid) begin
					s_nxt.pend      = 1'b0;
					s_nxt.first     = 1'b0;
					s_nxt.ntx_data  = b;
					s_nxt.ntx_valid = 1'b1;
					s_nxt.ntx_first = s_r.first;
					s_nxt.ntx_last  = (s_r.remain == 16'h0001) && !s_r.sum_en;
					s_nxt.sum       = s_r.sum + b;
					s_nxt.remain    = s_r.remain - 16'h0001;
					if (s_r.remain == 16'h0001) begin
						s_nxt.in_st = s_r.sum_en ? host_link_pkg::IN_SUM : host_link_pkg::IN_HDR;
					end
				end else if (s_r.pend && !s_r.is_net && !s_r.cmd_valid) begin
					s_nxt.pend      = 1'b0;
					s_nxt.cmd_data  = b;
					s_nxt.cmd_valid = 1'b1;
					s_nxt.cmd_first = 1'b0;
					s_nxt.cmd_last  = (s_r.remain == 16'h0001);
					s_nxt.remain    = s_r.remain - 16'h0001;
					if (s_r.remain == 16'h0001) begin
						s_nxt.in_st = host_link_pkg::IN_HDR;
					end
				end
			end
			host_link_pkg::IN_SUM: begin
				if (!s_r.ntx_valid) begin
					s_nxt.ntx_data  = s_r.sum;
					s_nxt.ntx_valid = 1'b1;
					s_nxt.ntx_first = 1'b0;
					s_nxt.ntx_last  = 1'b1;
					s_nxt.in_st     = host_link_pkg::IN_HDR;
				end
			end
			default: s_nxt.in_st = host_link_pkg::IN_HDR;
		endcase

		// Start of a network message: latch role and checksum option
		if (s_r.pend && !s_nxt.pend && (s_nxt.in_st == host_link_pkg::IN_BODY) && (s_r.in_st != host_link_pkg::IN_BODY)
				&& (s_r.in_st != host_link_pkg::IN_HDR || b[7:4] == `TYPE_NET_MSG)) begin
			s_nxt.is_net   = 1'b1;
			s_nxt.first    = 1'b1;
			s_nxt.sum      = 8'h00;
			s_nxt.sum_en   = sum_append_en;
			s_nxt.ntx_role = lin_mode ? host_link_pkg::lin_role_t'(lin_role) : host_link_pkg::ROLE_PASSIVE;
		end

		if (char_rx_valid) begin
			s_nxt.pend      = 1'b1;
			s_nxt.pend_data = char_rx_data;
		end
		s_nxt.rts = !s_nxt.pend;

		// Received network messages forwarded as responses
		case (s_r.rs_st)
			host_link_pkg::RS_COLLECT: begin
				if (net_rx_valid && s_r.nrx_ready) begin
					if (!(net_rx_last && strip_sum_en) && (s_r.rlen < 6'(`RESP_DEPTH))) begin
						s_nxt.rbuf[s_r.rlen[4:0]] = net_rx_data;
						s_nxt.rlen                = s_r.rlen + 6'h01;
					end
					if (net_rx_last) begin
						s_nxt.rstat     = net_rx_status;
						s_nxt.nrx_ready = 1'b0;
						s_nxt.rs_st     = host_link_pkg::RS_HDR;
					end
				end
			end
			host_link_pkg::RS_HDR: begin
				if (char_tx_valid && char_tx_ready) begin
					s_nxt.rs_st = (resp_total > `MAX_NORMAL_CNT) ? host_link_pkg::RS_CNT : host_link_pkg::RS_STAT;
				end
			end
			host_link_pkg::RS_CNT: begin
				if (char_tx_valid && char_tx_ready) begin
					s_nxt.rs_st = host_link_pkg::RS_STAT;
				end
			end
			host_link_pkg::RS_STAT: begin
				if (char_tx_valid && char_tx_ready) begin
					s_nxt.ridx = 5'h00;
					if (s_r.rlen == 6'h00) begin
						s_nxt.rs_st     = host_link_pkg::RS_COLLECT;
						s_nxt.nrx_ready = 1'b1;
					end else begin
						s_nxt.rs_st = host_link_pkg::RS_DATA;
					end
				end
			end
			host_link_pkg::RS_DATA: begin
				if (char_tx_valid && char_tx_ready) begin
					s_nxt.ridx = s_r.ridx + 5'h01;
					if ({1'b0, s_r.ridx} == s_r.rlen - 6'h01) begin
						s_nxt.rs_st     = host_link_pkg::RS_COLLECT;
						s_nxt.rlen      = 6'h00;
						s_nxt.nrx_ready = 1'b1;
					end
				end
			end
			default: s_nxt.rs_st = host_link_pkg::RS_COLLECT;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r           <= '0;
			s_r.rts       <= 1'b1;
			s_r.nrx_ready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule // host_serial_packet_link

`default_nettype wire

/* tb/host_port_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "host_link_defs.svh"

module host_port_model (
	input  wire logic clk,
	output logic      rxd,
	input  wire logic txd,
	output logic      cts,
	input  wire logic rts,
	input  wire logic cts_allow
);
	logic [7:0] rx_q[$];
	logic [7:0] sh;

	assign cts = cts_allow; // Hold off
	initial rxd = 1'b1;

	task automatic send(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0}; // Start, LSB first, stop
		@(posedge clk);
		while (!rts) @(posedge clk); // Wait for room
		for (int i = 0; i < 10; i++) begin
			rxd <= fr[i];
			repeat (`BIT_CYCLES) @(posedge clk);
		end
	endtask

	// Mid-bit sampling; low stop bit drops the character
	initial forever begin
		@(negedge txd);
		repeat (`BIT_CYCLES / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (`BIT_CYCLES) @(posedge clk);
			sh = {txd, sh[7:1]}; // LSB first
		end
		repeat (`BIT_CYCLES) @(posedge clk);
		if (txd === 1'b1) rx_q.push_back(sh); // Response bytes
	end
endmodule // host_port_model
`default_nettype wire

/* tb/host_link_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "host_link_defs.svh"

module host_link_checker (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       host_txd,
	input wire logic       host_rts,
	input wire logic       lin_mode,
	input wire logic [7:0] net_tx_data,
	input wire logic       net_tx_valid,
	input wire logic       net_tx_first,
	input wire logic       net_tx_last,
	input wire logic [1:0] net_tx_role,
	input wire logic       net_tx_ready,
	input wire logic [7:0] cmd_data,
	input wire logic       cmd_valid,
	input wire logic       cmd_first,
	input wire logic       cmd_last,
	input wire logic       cmd_ready,
	input wire logic       net_rx_valid,
	input wire logic       net_rx_last,
	input wire logic       net_rx_ready
);
	localparam int MAX_LOW = 9 * `BIT_CYCLES + 2;
	logic [15:0] low_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Longest legal low run: start bit plus eight zero bits
	always_ff @(posedge clk or posedge rst)
		if (rst) low_r <= 16'h0000;
		else low_r <= host_txd ? 16'h0000 : low_r + 16'h0001;

	sequence tx_take;
		net_tx_valid && net_tx_ready;
	endsequence
	sequence rx_end;
		net_rx_valid && net_rx_ready && net_rx_last;
	endsequence

	txd_frame_a: assert property (low_r <= MAX_LOW) else $error("host_txd low too long");
	reset_idle_a: assert property ($fell(rst) |-> host_txd && host_rts && !net_tx_valid && !cmd_valid)
		else $error("outputs not idle after reset");
	rts_free_a: assert property (!host_rts |-> ##[1:1000] host_rts) else $error("host_rts stuck low");
	tx_gap_a: assert property (tx_take |=> !net_tx_valid) else $error("net_tx_valid not dropped");
	tx_hold_a: assert property (net_tx_valid && !net_tx_ready |=> net_tx_valid && $stable(net_tx_data))
		else $error("net_tx byte not held");
	tx_mark_a: assert property (net_tx_first || net_tx_last |-> net_tx_valid) else $error("stray tx mark");
	tx_role_a: assert property (net_tx_valid && !lin_mode |-> net_tx_role == 2'h0) else $error("role outside LIN");
	cmd_hold_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
		else $error("cmd byte not held");
	cmd_mark_a: assert property (cmd_first || cmd_last |-> cmd_valid) else $error("stray cmd mark");
	rx_close_a: assert property (rx_end |=> !net_rx_ready [*8]) else $error("net_rx_ready not dropped");
endmodule // host_link_checker
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "host_link_defs.svh"

module tb;
	logic       clk;
	logic       rst;
	logic       host_rxd;
	logic       host_txd;
	logic       host_cts;
	logic       host_rts;
	logic       cts_allow;
	logic [7:0] net_tx_data;
	logic       net_tx_valid;
	logic       net_tx_first;
	logic       net_tx_last;
	logic [1:0] net_tx_role;
	logic       net_tx_ready;
	logic [7:0] cmd_data;
	logic       cmd_valid;
	logic       cmd_first;
	logic       cmd_last;
	logic       cmd_ready;
	logic [7:0] net_rx_data;
	logic       net_rx_valid;
	logic       net_rx_last;
	logic       net_rx_ready;
	logic       sum_append_en;
	logic       lin_mode;
	logic [1:0] lin_role;
	logic [7:0] net_rx_status;
	int         num_errors;
	int         n_checks;

	host_serial_packet_link host_serial_packet_link_i (
		.clk(clk), .rst(rst), .host_rxd(host_rxd), .host_txd(host_txd), .host_cts(host_cts),
		.host_rts(host_rts), .sum_append_en(sum_append_en), .strip_sum_en(1'b1), .lin_mode(lin_mode),
		.lin_role(lin_role), .net_tx_data(net_tx_data), .net_tx_valid(net_tx_valid),
		.net_tx_first(net_tx_first), .net_tx_last(net_tx_last), .net_tx_role(net_tx_role),
		.net_tx_ready(net_tx_ready), .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_first(cmd_first),
		.cmd_last(cmd_last), .cmd_ready(cmd_ready), .net_rx_data(net_rx_data),
		.net_rx_valid(net_rx_valid), .net_rx_last(net_rx_last), .net_rx_status(net_rx_status),
		.net_rx_ready(net_rx_ready)
	);

	host_port_model port_i (
		.clk(clk), .rxd(host_rxd), .txd(host_txd), .cts(host_cts), .rts(host_rts), .cts_allow(cts_allow)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic rx_byte(input logic [7:0] d, input logic l);
		net_rx_data <= d;
		net_rx_last <= l;
		net_rx_valid <= 1'b1;
		@(posedge clk);
		while (!net_rx_ready) @(posedge clk);
	endtask

	task automatic test_reset();
		check({host_txd, host_rts, net_rx_ready, net_tx_valid, cmd_valid}, 16'h001C); // Idle
		$display("test reset done");
	endtask

	// Command header alone, then a counted network message with both sides stalling
	task automatic test_inbound();
		logic [11:0] got[$];
		logic [9:0]  cmd_got;
		fork
			begin
				port_i.send(8'hD0);
				port_i.send(8'h02); // Type zero, count two
				port_i.send(8'hAA);
				port_i.send(8'hBB);
			end
			for (int i = 0; i < 95000 && got.size() < 3; i++) begin
				@(posedge clk);
				if (cmd_valid && cmd_ready) cmd_got = {cmd_first, cmd_last, cmd_data};
				if (net_tx_valid && net_tx_ready) begin
					got.push_back({net_tx_role, net_tx_first, net_tx_last, net_tx_data});
				end
				if (got.size() == 1) sum_append_en <= 1'b0; // Latched at message start
				net_tx_ready <= ~net_tx_ready;
				cmd_ready <= ~cmd_ready;
			end
		join
		check(cmd_got, {2'h3, 8'hD0}); // Header only packet
		check(got.size(), 16'h0003); // Header kept off network
		check(got[0], {2'h0, 2'h2, 8'hAA});
		check(got[1], {2'h0, 2'h0, 8'hBB});
		check(got[2], {2'h0, 2'h1, 8'(8'hAA + 8'hBB)}); // Appended sum
		check(got[0][11:10], 16'h0000); // Role passive outside LIN mode
		$display("test inbound done");
	endtask

	// Received message held back by the host, then forwarded with sum stripped
	task automatic test_response();
		logic quiet;
		quiet = 1'b1;
		rx_byte(8'hA7, 1'b0);
		net_rx_status <= 8'h5A;
		rx_byte(8'h3C, 1'b1);
		net_rx_valid <= 1'b0;
		lin_mode <= 1'b0;
		lin_role <= 2'h2;
		repeat (1000) begin
			@(posedge clk);
			quiet &= host_txd;
		end
		check(quiet, 16'h0001); // No send while host not ready
		cts_allow <= 1'b1;
		for (int i = 0; i < 80000 && port_i.rx_q.size() < 3; i++) @(posedge clk);
		check(port_i.rx_q.size(), 16'h0003); // Forwarded with LIN mode off
		check(port_i.rx_q[0], 16'h0002); // Type zero, count two
		check(port_i.rx_q[1], 16'h005A); // Status taken with last byte
		check(port_i.rx_q[2], 16'h00A7);
		$display("test response done");
	endtask

	initial begin
		rst = 1'b1;
		num_errors = 0;
		n_checks = 0;
		cts_allow = 1'b0;
		net_tx_ready = 1'b0;
		cmd_ready = 1'b0;
		net_rx_data = 8'h00;
		net_rx_valid = 1'b0;
		net_rx_last = 1'b0;
		net_rx_status = 8'h00;
		sum_append_en = 1'b1;
		lin_mode = 1'b1;
		lin_role = 2'h0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		test_reset();
		fork
			test_inbound();
			test_response();
		join
		test_done();
	end

	initial begin
		repeat (98000) @(posedge clk);
		num_errors++;
		$display("watchdog expired");
		test_done();
	end
endmodule // tb

bind host_serial_packet_link host_link_checker host_link_checker_i (
	.clk(clk), .rst(rst), .host_txd(host_txd), .host_rts(host_rts), .lin_mode(lin_mode),
	.net_tx_data(net_tx_data), .net_tx_valid(net_tx_valid), .net_tx_first(net_tx_first),
	.net_tx_last(net_tx_last), .net_tx_role(net_tx_role), .net_tx_ready(net_tx_ready),
	.cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_first(cmd_first), .cmd_last(cmd_last),
	.cmd_ready(cmd_ready), .net_rx_valid(net_rx_valid), .net_rx_last(net_rx_last),
	.net_rx_ready(net_rx_ready)
);
`default_nettype wire
